// ==== rtl/sbc_pkg.sv ====
package sbc_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned BLK_W  = 64;
  localparam int unsigned KEY_W  = 64;
  localparam int unsigned GPIO_W = 12;
  localparam int unsigned CORES  = 3;

  // Strap positions on the general-purpose pins.
  localparam int unsigned MODE_LSB   = 0;
  localparam int unsigned MODE_W     = 4;
  localparam int unsigned LAYOUT_BIT = 5;
  localparam int unsigned CFG_LSB    = 8;
  localparam int unsigned CFG_W      = 4;

  localparam logic [3:0] NUM_MODES = 4'hb;

  localparam int unsigned    PLL_MULT_W    = 6;
  localparam logic [5:0]     PLL_MULT_BOOT = 6'h10;

  localparam logic [6:0] I2C_ADDR_BASE = 7'h50;
  localparam logic [6:0] I2C_ADDR_ALT  = 7'h51;

  localparam logic [31:0] MAGIC_SHARED = 32'h008f_fffc;
  localparam logic [31:0] MAGIC_SPLIT2 = 32'h0087_fffc;
  localparam logic [31:0] NOBOOT_ENTRY = 32'h0080_0000;

  // Entry table index: {layout, selector}.
  localparam logic [1:0] ROM_SEL_SECROM = 2'h0;
  localparam logic [1:0] ROM_SEL_NOBOOT = 2'h1;
  localparam logic [1:0] ROM_SEL_MAGIC1 = 2'h2;
  localparam logic [1:0] ROM_SEL_MAGIC2 = 2'h3;

  localparam logic [2:0] CORES_ALL  = 3'h7;
  localparam logic [2:0] CORES_NONE = 3'h0;
  localparam logic [2:0] CORES_SEC  = 3'h6;

  typedef enum logic [3:0] {
    BM_NO_BOOT     = 4'h0,
    BM_I2C_MST     = 4'h1,
    BM_I2C_MST_ALT = 4'h2,
    BM_I2C_SLV     = 4'h3,
    BM_SRIO_0      = 4'h4,
    BM_SRIO_1      = 4'h5,
    BM_SRIO_2      = 4'h6,
    BM_SRIO_3      = 4'h7,
    BM_ETHERNET_MAC_PORT_MST    = 4'h8,
    BM_ETHERNET_MAC_PORT_SLV    = 4'h9,
    BM_ETHERNET_MAC_PORT_FORCED = 4'ha
  } sbc_mode_e;

  typedef enum logic [3:0] {
    S_SAMPLE  = 4'h0,
    S_DECODE  = 4'h1,
    S_PLL     = 4'h2,
    S_SECROM  = 4'h3,
    S_LOAD    = 4'h4,
    S_DECRYPT = 4'h5,
    S_AUTH    = 4'h6,
    S_ENTRY   = 4'h7,
    S_RUN     = 4'h8,
    S_HALT    = 4'h9
  } sbc_state_e;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic [CFG_W-1:0]  cfg;
    logic              layout;
  } sbc_straps_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BLK_W-1:0]  data;
  } sbc_word_s;

  typedef struct packed {
    sbc_state_e                  state;
    logic [2:0]                  step;
    sbc_straps_s                 straps;
    logic                        mode_ok;
    logic                        secure;
    logic                        encrypt;
    logic                        fault;
    logic [KEY_W-1:0]            key;
    logic [PLL_MULT_W-1:0]       pll_mult;
    logic                        pll_update;
    logic [6:0]                  i2c_addr;
    logic                        load_ready;
    logic                        last;
    sbc_word_s                   word;
    logic                        des_req;
    logic                        mem_wr_en;
    sbc_word_s                   mem_wr;
    logic [ADDR_W-1:0]           boot_entry;
    logic [2:0]                  rom_idx;
    logic [CORES-1:0]            core_rst_n;
    logic [CORES-1:0]            core_hold;
    logic [CORES-1:0][ADDR_W-1:0] core_entry;
    logic                        page_alloc;
    logic                        ext_gnt;
    logic                        ext_deny;
    logic                        boot_done;
  } sbc_state_s;

  localparam sbc_state_s STATE_RST = '0;

endpackage

// ==== rtl/sbc_entry_rom.sv ====
`timescale 1ns/100ps
module sbc_entry_rom
  import sbc_pkg::*;
#(
  parameter logic [ADDR_W-1:0] SEC_ROM_ENTRY = 32'h0010_0000
) (
  input  wire logic              sys_clk, // System clock.
  input  wire logic              srst,    // Synchronous reset.
  input  wire logic [2:0]        rd_idx,  // Index {layout, selector}.
  output logic      [ADDR_W-1:0] rd_data  // Registered entry address.
);

  logic [ADDR_W-1:0] next_rd_data;

  always_comb begin
    case (rd_idx[1:0])
      ROM_SEL_SECROM: next_rd_data = SEC_ROM_ENTRY;
      ROM_SEL_NOBOOT: next_rd_data = NOBOOT_ENTRY;
      ROM_SEL_MAGIC1: next_rd_data = MAGIC_SHARED;
      // Layout 0 splits the two secondary cores onto separate magic words.
      ROM_SEL_MAGIC2: next_rd_data = rd_idx[2] ? MAGIC_SHARED : MAGIC_SPLIT2;
      default:        next_rd_data = NOBOOT_ENTRY;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule

// ==== rtl/sbc_boot_ctrl.sv ====
`timescale 1ns/100ps
module sbc_boot_ctrl
  import sbc_pkg::*;
#(
  parameter logic [ADDR_W-1:0] SEC_ROM_ENTRY = 32'h0010_0000
) (
  input  wire logic                          sys_clk,        // 40 MHz clock.
  input  wire logic                          srst,           // Synchronous reset, high.
  input  wire logic [GPIO_W-1:0]             gpio_in,        // Strap pins.
  input  wire logic                          fuse_secure,    // Security fuse programmed.
  input  wire logic                          fuse_key_valid, // Key fuses programmed.
  input  wire logic [KEY_W-1:0]              fuse_key,       // Fused decryption key.
  input  wire logic                          main_pll_lock,  // Main PLL locked.
  input  wire logic                          load_valid,     // Image word offered.
  input  wire sbc_word_s                     load_word,      // Image address and data.
  input  wire logic                          load_last,      // Last word of image.
  input  wire logic [ADDR_W-1:0]             load_entry,     // Boot table entry.
  input  wire logic                          des_done,       // Decryption finished.
  input  wire logic [BLK_W-1:0]              des_plain,      // Decrypted block.
  input  wire logic                          auth_done,      // Authentication finished.
  input  wire logic                          auth_ok,        // Image authentic.
  input  wire logic                          ext_req,        // External memory request.
  output logic                               load_ready,     // Ready for a word.
  output logic                               des_req,        // Decryption request.
  output logic [KEY_W-1:0]                   des_key,        // Key for decryption.
  output logic [BLK_W-1:0]                   des_block,      // Cipher block.
  output logic                               mem_wr_en,      // Internal memory write.
  output sbc_word_s                          mem_wr,         // Write address and data.
  output sbc_straps_s                        straps,         // Latched straps.
  output logic                               mode_ok,        // Mode code supported.
  output logic                               secure_boot,    // Secure variant active.
  output logic                               boot_fault,     // Boot aborted.
  output logic [PLL_MULT_W-1:0]              main_pll_mult,  // Main PLL multiplier.
  output logic                               main_pll_update,// Multiplier load pulse.
  output logic [6:0]                         i2c_slave_addr, // I2C master target.
  output logic [CORES-1:0]                   core_rst_n,     // Core resets, low.
  output logic [CORES-1:0]                   core_hold,      // Core waits at entry.
  output logic [CORES-1:0][ADDR_W-1:0]       core_entry,     // Core entry addresses.
  output logic                               ram_page_alloc, // Page allocation pulse.
  output logic                               ext_gnt,        // External access granted.
  output logic                               ext_deny,       // External access denied.
  output logic                               boot_done       // All cores running.
);

  sbc_state_s        st;
  sbc_state_s        next_st;
  // Read data of the entry table, valid one cycle after its index.
  logic [ADDR_W-1:0] rom_q;

  // The table and its index are registered, so every read is issued two cycles before it is used.
  sbc_entry_rom #(
    .SEC_ROM_ENTRY (SEC_ROM_ENTRY)
  ) u_rom (
    .sys_clk (sys_clk),
    .srst    (srst),
    .rd_idx  (st.rom_idx),
    .rd_data (rom_q)
  );

  always_comb begin
    // Pulses last one cycle unless a state raises them again.
    next_st            = st;
    next_st.pll_update = 1'b0;
    next_st.page_alloc = 1'b0;
    next_st.mem_wr_en  = 1'b0;
    next_st.ext_gnt    = 1'b0;
    next_st.ext_deny   = 1'b0;

    // The gate answers in every state, so no outside agent slips in while boot runs on a part with fuse_secure set.
    // Fuse blocks externals.
    // Only internal memory is gated; peripheral and DDR2 paths bypass this block.
    if (ext_req) begin
      next_st.ext_gnt  = ~fuse_secure;
      next_st.ext_deny = fuse_secure;
    end

    case (st.state)
      S_SAMPLE: begin
        // Pins are read in the first cycle after reset only; the board may reuse them later.
        // Straps latched once.
        next_st.straps.mode   = gpio_in[MODE_LSB +: MODE_W];
        next_st.straps.cfg    = gpio_in[CFG_LSB +: CFG_W];
        next_st.straps.layout = gpio_in[LAYOUT_BIT];
        next_st.state         = S_DECODE;
      end
      S_DECODE: begin
        // Other codes unsupported.
        // Codes above the last mode name interfaces that this part does not have.
        next_st.mode_ok    = st.straps.mode < NUM_MODES;
        next_st.i2c_addr   = (st.straps.mode == BM_I2C_MST_ALT) ? I2C_ADDR_ALT
                                                                 : I2C_ADDR_BASE;
        next_st.secure     = fuse_secure;
        next_st.encrypt    = fuse_key_valid;
        // The key is copied once, so the cipher engine sees one value for the whole image.
        next_st.key        = fuse_key;
        next_st.pll_mult   = PLL_MULT_BOOT;
        next_st.pll_update = 1'b1;
        next_st.state      = S_PLL;
      end
      S_PLL: begin
        // Nothing is loaded before lock, since the load path runs from the multiplied clock.
        if (main_pll_lock) begin
          next_st.step = 3'h0;
          if (!st.mode_ok) begin
            next_st.fault = 1'b1;
            next_st.state = S_HALT;
          end else if (st.secure) begin
            next_st.rom_idx = {st.straps.layout, ROM_SEL_SECROM};
            next_st.state   = S_SECROM;
          end else if (st.straps.mode == BM_NO_BOOT) begin
            next_st.state = S_ENTRY;
          end else begin
            next_st.load_ready = 1'b1;
            next_st.state      = S_LOAD;
          end
        end
      end
      S_SECROM: begin
        // Entry table answers one cycle after the index is registered.
        if (st.step == 3'h0) begin
          next_st.step = 3'h1;
        end else begin
          next_st.core_entry = {CORES{rom_q}};
          next_st.core_rst_n = CORES_ALL;
          next_st.core_hold  = CORES_SEC;
          next_st.page_alloc = 1'b1;
          next_st.step       = 3'h0;
          // The no-boot code brings no image, so it goes straight to the check.
          if (st.straps.mode == BM_NO_BOOT) begin
            next_st.state = S_AUTH;
          end else begin
            next_st.load_ready = 1'b1;
            next_st.state      = S_LOAD;
          end
        end
      end
      S_LOAD: begin
        // A word offered while load_ready is low stays on the bus and is taken later.
        // Same path for pushed and pulled images.
        if (load_valid && st.load_ready) begin
          next_st.load_ready = 1'b0;
          next_st.word       = load_word;
          next_st.last       = load_last;
          if (load_last) begin
            next_st.boot_entry = load_entry;
          end
          if (st.encrypt) begin
            next_st.des_req = 1'b1;
            next_st.state   = S_DECRYPT;
          end else begin
            // Plain words are written back to back, one per cycle.
            next_st.mem_wr_en = 1'b1;
            next_st.mem_wr    = load_word;
            if (load_last) begin
              next_st.state = st.secure ? S_AUTH : S_ENTRY;
            end else begin
              next_st.load_ready = 1'b1;
            end
          end
        end
      end
      S_DECRYPT: begin
        // One block is in flight at a time, trading load rate for an engine without a queue.
        if (des_done) begin
          next_st.des_req     = 1'b0;
          next_st.mem_wr_en   = 1'b1;
          next_st.mem_wr.addr = st.word.addr;
          next_st.mem_wr.data = des_plain;
          if (st.last) begin
            next_st.state = st.secure ? S_AUTH : S_ENTRY;
          end else begin
            next_st.load_ready = 1'b1;
            next_st.state      = S_LOAD;
          end
        end
      end
      S_AUTH: begin
        if (auth_done) begin
          if (auth_ok) begin
            next_st.step  = 3'h0;
            next_st.state = S_ENTRY;
          end else begin
            // A rejected image puts every core back into reset at once.
            next_st.fault      = 1'b1;
            next_st.core_rst_n = CORES_NONE;
            next_st.state      = S_HALT;
          end
        end
      end
      S_ENTRY: begin
        // Public boot keeps every core in reset until this walk is done.
        // Walks the entry table; each read lands two steps after its index.
        case (st.step)
          3'h0: begin
            next_st.rom_idx = {st.straps.layout, ROM_SEL_MAGIC1};
          end
          3'h1: begin
            next_st.rom_idx = {st.straps.layout, ROM_SEL_MAGIC2};
          end
          3'h2: begin
            next_st.core_entry[1] = rom_q;
            next_st.rom_idx       = {st.straps.layout, ROM_SEL_NOBOOT};
          end
          3'h3: begin
            next_st.core_entry[2] = rom_q;
          end
          default: begin
            // Core 0 jumps to boot table entry, or to the no-boot entry in no-boot mode.
            next_st.core_entry[0] = (st.straps.mode == BM_NO_BOOT) ? rom_q
                                                                  : st.boot_entry;
            next_st.state         = S_RUN;
          end
        endcase
        if (st.step != 3'h4) begin
          next_st.step = st.step + 3'h1;
        end
      end
      S_RUN: begin
        // This state is final; only a new reset starts another boot.
        // Release secondary cores.
        next_st.core_rst_n = CORES_ALL;
        next_st.core_hold  = CORES_NONE;
        next_st.boot_done  = 1'b1;
      end
      S_HALT: begin
        // A failed secure boot must not leave any core running loaded code.
        // Loading stops too, so a half-written image is never completed.
        next_st.core_rst_n = CORES_NONE;
        next_st.load_ready = 1'b0;
        next_st.des_req    = 1'b0;
      end
      default: begin
        next_st.state = S_HALT;
      end
    endcase
  end

  // One register holds every state bit, so the reset value is a single constant.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a bit of the state register, so none glitches between edges.
  assign load_ready      = st.load_ready;
  assign des_req         = st.des_req;
  assign des_key         = st.key;
  assign des_block       = st.word.data;
  assign mem_wr_en       = st.mem_wr_en;
  assign mem_wr          = st.mem_wr;
  assign straps          = st.straps;
  assign mode_ok         = st.mode_ok;
  assign secure_boot     = st.secure;
  assign boot_fault      = st.fault;
  assign main_pll_mult   = st.pll_mult;
  assign main_pll_update = st.pll_update;
  assign i2c_slave_addr  = st.i2c_addr;
  assign core_rst_n      = st.core_rst_n;
  assign core_hold       = st.core_hold;
  assign core_entry      = st.core_entry;
  assign ram_page_alloc  = st.page_alloc;
  assign ext_gnt         = st.ext_gnt;
  assign ext_deny        = st.ext_deny;
  assign boot_done       = st.boot_done;

endmodule

// ==== verif/sbc_boot_ctrl_properties.sv ====
`timescale 1ns/100ps
module sbc_boot_ctrl_properties
  import sbc_pkg::*;
(
  input wire logic                         sys_clk,         // Clock.
  input wire logic                         srst,            // Reset.
  input wire logic [GPIO_W-1:0]            gpio_in,         // Straps.
  input wire sbc_straps_s                  straps,          // Latched straps.
  input wire logic [PLL_MULT_W-1:0]        main_pll_mult,   // Multiplier.
  input wire logic                         main_pll_update, // Load pulse.
  input wire logic [6:0]                   i2c_slave_addr,  // I2C target.
  input wire logic                         mode_ok,         // Code valid.
  input wire logic                         ext_req,         // Access request.
  input wire logic                         fuse_secure,     // Secure part.
  input wire logic                         ext_gnt,         // Granted.
  input wire logic                         ext_deny,        // Denied.
  input wire logic                         des_req,         // Cipher request.
  input wire logic                         des_done,        // Cipher done.
  input wire logic [BLK_W-1:0]             des_plain,       // Plain block.
  input wire logic                         mem_wr_en,       // Write pulse.
  input wire sbc_word_s                    mem_wr,          // Write word.
  input wire logic                         boot_done,       // Running.
  input wire logic [CORES-1:0][ADDR_W-1:0] core_entry,      // Entries.
  input wire logic                         secure_boot,     // Secure variant.
  input wire logic                         load_ready,      // Load ready.
  input wire logic [CORES-1:0]             core_rst_n,      // Core resets.
  input wire logic [CORES-1:0]             core_hold,       // Core waits.
  input wire logic                         boot_fault       // Aborted.
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  strap_capture_a: assert property ($fell(srst) |=> straps.mode == $past(gpio_in[3:0])
    && straps.cfg == $past(gpio_in[11:8]) && straps.layout == $past(gpio_in[5]))
    else $error("straps differ from pins at capture");
  strap_hold_a: assert property (!$past(srst) && !$past(srst, 2) |-> $stable(straps))
    else $error("straps changed after capture");
  pll_boot_a: assert property ($fell(srst) |-> ##2 main_pll_update
    && main_pll_mult == PLL_MULT_BOOT) else $error("pll not set to sixteen");
  i2c_target_a: assert property ($fell(srst) |-> ##2 i2c_slave_addr ==
    ((straps.mode == 4'h2) ? I2C_ADDR_ALT : I2C_ADDR_BASE)) else $error("bad i2c target");
  mode_check_a: assert property ($fell(srst) |-> ##2 mode_ok == (straps.mode < NUM_MODES))
    else $error("mode_ok wrong");
  access_deny_a: assert property (ext_req && fuse_secure |=> ext_deny && !ext_gnt)
    else $error("secure part granted access");
  decrypt_write_a: assert property (des_req && des_done |=> mem_wr_en
    && mem_wr.data == $past(des_plain)) else $error("plain block not written");
  magic_entry_a: assert property (boot_done |-> core_entry[1] == MAGIC_SHARED
    && core_entry[2] == (straps.layout ? MAGIC_SHARED : MAGIC_SPLIT2)) else $error("bad magic");
  secure_park_a: assert property (secure_boot && load_ready |-> core_rst_n == CORES_ALL
    && core_hold == CORES_SEC) else $error("cores not parked in secure load");
  fault_hold_a: assert property ($rose(boot_fault) |-> (boot_fault && core_rst_n == CORES_NONE
    && !boot_done) [*4]) else $error("fault not held with cores in reset");

  cover property (boot_done && secure_boot);
  cover property (boot_fault);
  cover property (des_req && des_done);
endmodule

bind sbc_boot_ctrl sbc_boot_ctrl_properties u_props (.*);

// ==== verif/sbc_boot_src.sv ====
`timescale 1ns/100ps
module sbc_boot_src
  import sbc_pkg::*;
#(
  parameter int unsigned       WORDS = 3,
  parameter logic [ADDR_W-1:0] ENTRY = 32'h0082_0000
) (
  input wire logic               sys_clk,    // Clock.
  input wire logic               srst,       // Reset.
  input wire logic               stall,      // Source slow.
  input wire logic               load_ready, // Block takes.
  output logic                   load_valid, // Word offered.
  output sbc_word_s              load_word,  // Word.
  output logic                   load_last,  // Last word.
  output logic [ADDR_W-1:0]      load_entry  // Entry.
);
  int unsigned idx;

  function automatic sbc_word_s word_at(input int unsigned k);
    return '{addr: 32'h0081_0000 + 32'(8 * k), data: 64'h0123_4567_89ab_cdef ^ 64'(k)};
  endfunction

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      idx <= 0;
      load_valid <= 1'b0;
      load_word <= ~word_at(0);
    end else if (load_valid && load_ready) begin
      idx <= idx + 1;
      load_valid <= (idx + 1 < WORDS) && !stall;
      load_word <= ((idx + 1 < WORDS) && !stall) ? word_at(idx + 1) : ~load_word;
    end else if (!load_valid && idx < WORDS && !stall) begin
      load_valid <= 1'b1;
      load_word <= word_at(idx);
    end
  end

  assign load_last = load_valid && (idx == WORDS - 1);
  assign load_entry = ENTRY;
endmodule

// ==== verif/secure_multicore_boot_config_tb_top.sv ====
`timescale 1ns/100ps
module secure_multicore_boot_config_tb_top;
  import sbc_pkg::*;
  logic sys_clk, srst, fuse_secure, fuse_key_valid, main_pll_lock, des_done;
  logic auth_done, auth_ok, ext_req, stall, enc, load_valid, load_last, load_ready;
  logic des_req, mem_wr_en, mode_ok, secure_boot, boot_fault, main_pll_update;
  logic ram_page_alloc, ext_gnt, ext_deny, boot_done;
  logic [GPIO_W-1:0]            gpio_in;
  logic [KEY_W-1:0]             fuse_key, des_key;
  logic [BLK_W-1:0]             des_plain, des_block, exp_data;
  logic [ADDR_W-1:0]            load_entry;
  logic [PLL_MULT_W-1:0]        main_pll_mult;
  logic [6:0]                   i2c_slave_addr;
  logic [CORES-1:0]             core_rst_n, core_hold;
  logic [CORES-1:0][ADDR_W-1:0] core_entry;
  sbc_word_s                    load_word, mem_wr;
  sbc_straps_s                  straps;
  int                           mismatches, comparisons, wr_cnt;

  sbc_boot_ctrl u_dut (.*);
  sbc_boot_src u_src (.*);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // The cipher engine answers half a cycle after each request, on the falling edge.
  always @(negedge sys_clk) begin
    des_done <= des_req;
    des_plain <= ~des_block;
  end

  always @(negedge sys_clk) begin
    if (!srst && mem_wr_en) begin
      exp_data = 64'h0123_4567_89ab_cdef ^ 64'(wr_cnt);
      chk("mem_wr", {32'h0081_0000 + 32'(8 * wr_cnt), enc ? ~exp_data : exp_data}, mem_wr);
      wr_cnt++;
    end
  end

  task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // board drives the straps through reset
  task automatic boot(input logic [11:0] g, input logic sec, input logic keyv);
    @(negedge sys_clk);
    srst = 1'b1;
    gpio_in = g;
    fuse_secure = sec;
    fuse_key_valid = keyv;
    enc = keyv;
    wr_cnt = 0;
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic wait_end();
    int n;
    n = 0;
    while (boot_done !== 1'b1 && boot_fault !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 400) begin
        mismatches++;
        print_verdict();
      end
    end
  endtask

  task automatic test_public_alt();
    stall = 1'b1;
    boot(12'h502, 1'b0, 1'b0);
    chk("straps", {4'h2, 4'h5, 1'b0}, straps);
    gpio_in = 12'hfff;
    @(negedge sys_clk);
    chk("pll", {1'b1, 6'h10}, {main_pll_update, main_pll_mult});
    chk("i2c_addr", 7'h51, i2c_slave_addr);
    ext_req = 1'b1;
    @(negedge sys_clk);
    ext_req = 1'b0;
    chk("ext_gnt", 2'b10, {ext_gnt, ext_deny});
    repeat (12) @(negedge sys_clk);
    stall = 1'b0;
    wait_end();
    chk("straps_held", {4'h2, 4'h5, 1'b0}, straps);
    chk("entry", {32'h0087_fffc, 32'h008f_fffc, 32'h0082_0000}, core_entry);
    chk("cores", {3'h7, 3'h0, 1'b1}, {core_rst_n, core_hold, boot_done});
    chk("words", 3, wr_cnt);
    $display("test public_alt done");
  endtask

  task automatic test_secure_enc();
    int n;
    stall = 1'b0;
    boot(12'h021, 1'b1, 1'b1);
    @(negedge sys_clk);
    chk("secure", {1'b1, 7'h50}, {secure_boot, i2c_slave_addr});
    chk("des_key", fuse_key, des_key);
    ext_req = 1'b1;
    @(negedge sys_clk);
    ext_req = 1'b0;
    chk("ext_deny", 2'b01, {ext_gnt, ext_deny});
    for (n = 0; n < 20 && load_ready !== 1'b1; n++) @(negedge sys_clk);
    chk("parked", {3'h7, 3'h6, 1'b1}, {core_rst_n, core_hold, ram_page_alloc});
    wait_end();
    chk("entry", {32'h008f_fffc, 32'h008f_fffc, 32'h0082_0000}, core_entry);
    chk("done", {3'h7, 2'b10}, {core_rst_n, boot_done, boot_fault});
    chk("words", 3, wr_cnt);
    $display("test secure_enc done");
  endtask

  task automatic test_mode_codes();
    for (int m = 0; m < 16; m++) begin
      boot({8'h00, 4'(m)}, 1'b0, 1'b0);
      wait_end();
      chk("mode_ok", m < 11, mode_ok);
      chk("outcome", (m < 11) ? 2'b10 : 2'b01, {boot_done, boot_fault});
      if (m == 0) begin
        chk("noboot", 32'h0080_0000, core_entry[0]);
      end
    end
    $display("test mode_codes done");
  endtask

  task automatic test_auth_fail();
    auth_ok = 1'b0;
    boot(12'h000, 1'b1, 1'b0);
    wait_end();
    chk("auth_fail", {1'b0, 1'b1, 3'h0}, {boot_done, boot_fault, core_rst_n});
    auth_ok = 1'b1;
    $display("test auth_fail done");
  endtask

  initial begin
    srst = 1'b1;
    gpio_in = '0;
    fuse_secure = 1'b0;
    fuse_key_valid = 1'b0;
    fuse_key = 64'h1357_9bdf_0246_8ace;
    main_pll_lock = 1'b1;
    auth_done = 1'b1;
    auth_ok = 1'b1;
    ext_req = 1'b0;
    stall = 1'b0;
    enc = 1'b0;
    test_public_alt();
    test_secure_enc();
    test_mode_codes();
    test_auth_fail();
    print_verdict();
  end
endmodule
